// ==== hw/cpi_pkg.sv ====
// Shared constants, states and carriers for the cascaded controller pair.
package cpi_pkg;
   // ------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_M_ONE = 8'h20;
   localparam logic [7:0] IDX_M_ODD = 8'h21;
   localparam logic [7:0] IDX_S_ONE = 8'ha0;
   localparam logic [7:0] IDX_S_ODD = 8'ha1;
   localparam logic [7:0] IDX_STATUS = 8'h10;
   localparam logic [7:0] IDX_VECTOR = 8'h11;
   localparam logic [7:0] IDX_PEND = 8'h12;
   localparam logic [7:0] IDX_ACK = 8'h13;
   // ------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------
   localparam int SEL_BIT = 4;
   localparam int SENSE_BIT = 3;
   localparam int OP3_BIT = 3;
   localparam int BASE_LSB = 3;
   localparam logic [2:0] CASCADE_IN = 3'h2;
   localparam int ACK_VALID_BIT = 8;
   localparam logic [4:0] RST_BASE = 5'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // ------------------------------------------------------------
   // Types.
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CPI_UNINIT,
      CPI_WANT_TWO,
      CPI_WANT_THREE,
      CPI_WANT_FOUR,
      CPI_READY
   } cpi_seq_t;

   typedef struct packed {
      cpi_seq_t seq;
      logic ls;
      logic [4:0] base;
      logic [7:0] cascade;
      logic [7:0] mask;
      logic [7:0] pend;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] sync3;
      logic [7:0] lvl;
   } cpi_ctl_t;

   typedef struct packed {
      logic valid;
      logic slave;
      logic word_three;
      logic [7:0] data;
   } cpi_op_t;

   typedef struct packed {
      cpi_ctl_t [1:0] ctl;
      cpi_op_t op;
      logic rd_done;
      logic [31:0] rdata;
   } cpi_state_t;
endpackage

// ==== hw/cpi_top.sv ====
// Initialization word path and request logic of a master and slave controller pair.
`timescale 1ns/1ns
// What this block does
// - Even write with bit 4 is first word
// - Bit 3 picks edge or level sensing
// - Edge mode registers a rising transition
// - Sensing applies to all inputs of one controller together, except master input two when it cascades the internal slave
// - Controller ignores requests until fully initialized
// - Second word bits 7-3 form vector base
// - Master third word bits 7-1 mark slaves
// - Master bit 2 cascades internal slave
// - Master bit 1 marks slave on input one
module cpi_top (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Avalon-MM slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Request pins
   input wire logic [7:0] i_irq_master,
   input wire logic [7:0] i_irq_slave,
   // Core interrupt and operation word strobe
   output logic o_core_int,
   output cpi_pkg::cpi_op_t o_op_word
);
   cpi_pkg::cpi_state_t s;
   cpi_pkg::cpi_state_t next_s;
   logic [7:0] idx;
   logic wr_ok;
   logic rd_take;
   logic [7:0] rise_m;
   logic [7:0] rise_s;
   logic [7:0] pin_rise_m;
   logic [7:0] live_m;
   logic [7:0] live_s;
   logic [3:0] win_m;
   logic [3:0] win_s;
   logic casc_hit;

   // ------------------------------------------------------------
   // Lowest numbered active input wins; bit 3 flags a winner.
   // ------------------------------------------------------------
   function automatic logic [3:0] pick(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 7; k >= 0; k--) begin
         if (v[k]) begin
            r = {1'b1, 3'(k)};
         end
      end
      return r;
   endfunction

   assign idx = i_avs_address[9:2];
   assign wr_ok = i_avs_write;
   assign rd_take = i_avs_read && !s.rd_done;
   assign o_avs_waitrequest = rd_take;
   assign o_avs_readdata = s.rdata;
   assign o_op_word = s.op;
   assign live_m = s.ctl[0].pend & ~s.ctl[0].mask;
   assign live_s = s.ctl[1].pend & ~s.ctl[1].mask;
   assign win_m = pick(live_m);
   assign win_s = pick(live_s);
   assign casc_hit = win_m[2:0] == cpi_pkg::CASCADE_IN && s.ctl[0].cascade[2] && win_s[3];
   assign rise_m = s.ctl[0].sync2 & s.ctl[0].sync3 & ~s.ctl[0].lvl;
   assign rise_s = s.ctl[1].sync2 & s.ctl[1].sync3 & ~s.ctl[1].lvl;
   // Input two follows the internal slave when cascaded, so its pin edge is not a request.
   assign pin_rise_m = rise_m & ~{5'h00, s.ctl[0].cascade[2], 2'h0};
   assign o_core_int = win_m[3];

   // ------------------------------------------------------------
   // Next state.
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] agreed;
      logic [7:0] rise;
      logic [7:0] raw;
      logic c;
      agreed = 8'h00;
      rise = 8'h00;
      raw = 8'h00;
      c = 1'b0;
      next_s = s;
      next_s.op.valid = 1'b0;
      next_s.rd_done = rd_take;
      for (int n = 0; n < 2; n++) begin
         raw = (n == 0) ? i_irq_master : i_irq_slave;
         next_s.ctl[n].sync1 = raw;
         next_s.ctl[n].sync2 = s.ctl[n].sync1;
         next_s.ctl[n].sync3 = s.ctl[n].sync2;
         // A level counts once the second and third stages agree.
         agreed = ~(s.ctl[n].sync2 ^ s.ctl[n].sync3);
         next_s.ctl[n].lvl = (agreed & s.ctl[n].sync3) | (~agreed & s.ctl[n].lvl);
         rise = agreed & s.ctl[n].sync3 & ~s.ctl[n].lvl;
         if (s.ctl[n].seq == cpi_pkg::CPI_READY) begin
            if (s.ctl[n].ls) begin
               next_s.ctl[n].pend = next_s.ctl[n].lvl;
            end else begin
               next_s.ctl[n].pend = s.ctl[n].pend | rise;
            end
         end
      end
      // The internal slave drives master input two as a level.
      if (s.ctl[0].cascade[2] && s.ctl[0].seq == cpi_pkg::CPI_READY) begin
         next_s.ctl[0].pend[2] = win_s[3];
      end
      // Reads; the acknowledge read clears the serviced edge request.
      if (rd_take) begin
         unique case (idx)
            cpi_pkg::IDX_STATUS: begin
               next_s.rdata = {s.ctl[1].mask, s.ctl[0].mask, s.ctl[0].cascade, 4'h0,
                  s.ctl[1].ls, s.ctl[1].seq == cpi_pkg::CPI_READY,
                  s.ctl[0].ls, s.ctl[0].seq == cpi_pkg::CPI_READY};
            end
            cpi_pkg::IDX_VECTOR: begin
               next_s.rdata = {16'h0000, 3'h0, s.ctl[1].base, 3'h0, s.ctl[0].base};
            end
            cpi_pkg::IDX_PEND: begin
               next_s.rdata = {16'h0000, s.ctl[1].pend, s.ctl[0].pend};
            end
            cpi_pkg::IDX_ACK: begin
               next_s.rdata = cpi_pkg::RST_WORD;
               if (casc_hit) begin
                  next_s.rdata[cpi_pkg::ACK_VALID_BIT] = 1'b1;
                  next_s.rdata[7:0] = {s.ctl[1].base, win_s[2:0]};
                  if (!s.ctl[1].ls) begin
                     // A fresh edge on the same input wins over this clear.
                     next_s.ctl[1].pend[win_s[2:0]] = rise_s[win_s[2:0]];
                  end
               end else if (win_m[3]) begin
                  next_s.rdata[cpi_pkg::ACK_VALID_BIT] = 1'b1;
                  next_s.rdata[7:0] = {s.ctl[0].base, win_m[2:0]};
                  if (!s.ctl[0].ls) begin
                     // A fresh edge on the same input wins over this clear.
                     next_s.ctl[0].pend[win_m[2:0]] = rise_m[win_m[2:0]];
                  end
               end
            end
            default: begin
               next_s.rdata = cpi_pkg::RST_WORD;
            end
         endcase
      end
      // Writes; never high together with a read.
      if (wr_ok) begin
         c = idx == cpi_pkg::IDX_S_ONE || idx == cpi_pkg::IDX_S_ODD;
         if (idx == cpi_pkg::IDX_M_ONE || idx == cpi_pkg::IDX_S_ONE) begin
            if (i_avs_writedata[cpi_pkg::SEL_BIT]) begin
               next_s.ctl[c].seq = cpi_pkg::CPI_WANT_TWO;
               next_s.ctl[c].ls = i_avs_writedata[cpi_pkg::SENSE_BIT];
               next_s.ctl[c].mask = cpi_pkg::RST_BYTE;
               next_s.ctl[c].pend = cpi_pkg::RST_BYTE;
            end else begin
               next_s.op.valid = 1'b1;
               next_s.op.slave = c;
               next_s.op.word_three = i_avs_writedata[cpi_pkg::OP3_BIT];
               next_s.op.data = i_avs_writedata[7:0];
            end
         end else if (idx == cpi_pkg::IDX_M_ODD || idx == cpi_pkg::IDX_S_ODD) begin
            unique case (s.ctl[c].seq)
               cpi_pkg::CPI_WANT_TWO: begin
                  next_s.ctl[c].base = i_avs_writedata[7:cpi_pkg::BASE_LSB];
                  next_s.ctl[c].seq = cpi_pkg::CPI_WANT_THREE;
               end
               cpi_pkg::CPI_WANT_THREE: begin
                  if (!c) begin
                     next_s.ctl[0].cascade = {i_avs_writedata[7:1], 1'b0};
                  end
                  next_s.ctl[c].seq = cpi_pkg::CPI_WANT_FOUR;
               end
               cpi_pkg::CPI_WANT_FOUR: begin
                  next_s.ctl[c].seq = cpi_pkg::CPI_READY;
               end
               cpi_pkg::CPI_READY: begin
                  next_s.ctl[c].mask = i_avs_writedata[7:0];
               end
               cpi_pkg::CPI_UNINIT: begin
                  next_s.ctl[c].seq = cpi_pkg::CPI_UNINIT;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         for (int n = 0; n < 2; n++) begin
            s.ctl[n].seq <= cpi_pkg::CPI_UNINIT;
            s.ctl[n].ls <= 1'b0;
            s.ctl[n].base <= cpi_pkg::RST_BASE;
            s.ctl[n].cascade <= cpi_pkg::RST_BYTE;
            s.ctl[n].mask <= cpi_pkg::RST_BYTE;
            s.ctl[n].pend <= cpi_pkg::RST_BYTE;
            s.ctl[n].sync1 <= cpi_pkg::RST_BYTE;
            s.ctl[n].sync2 <= cpi_pkg::RST_BYTE;
            s.ctl[n].sync3 <= cpi_pkg::RST_BYTE;
            s.ctl[n].lvl <= cpi_pkg::RST_BYTE;
         end
         s.op <= '0;
         s.rd_done <= 1'b0;
         s.rdata <= cpi_pkg::RST_WORD;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   // Word routing on the shared even index.
   sel_one_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ONE && i_avs_writedata[cpi_pkg::SEL_BIT])
      |=> s.ctl[0].seq == cpi_pkg::CPI_WANT_TWO && s.ctl[0].mask == 8'h00
      && !o_op_word.valid)
      else $error("first word not taken");
   op_route_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_S_ONE && !i_avs_writedata[cpi_pkg::SEL_BIT])
      |=> o_op_word.valid && o_op_word.slave && $stable(s.ctl[1].seq))
      else $error("operation word not routed");
   op_master_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ONE && !i_avs_writedata[cpi_pkg::SEL_BIT])
      |=> o_op_word.valid && !o_op_word.slave
      && o_op_word.data == $past(i_avs_writedata[7:0]) && $stable(s.ctl[0].seq))
      else $error("master operation word not routed");
   // Sense choice is one bit per controller.
   sense_take_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_S_ONE && i_avs_writedata[cpi_pkg::SEL_BIT])
      |=> s.ctl[1].ls == $past(i_avs_writedata[cpi_pkg::SENSE_BIT]))
      else $error("sense bit not stored");
   sense_master_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ONE && i_avs_writedata[cpi_pkg::SEL_BIT])
      |=> s.ctl[0].ls == $past(i_avs_writedata[cpi_pkg::SENSE_BIT]))
      else $error("master sense bit not stored");
   edge_pend_a: assert property (
      (s.ctl[0].seq == cpi_pkg::CPI_READY && !s.ctl[0].ls && !wr_ok && !rd_take)
      |=> (s.ctl[0].pend & $past(pin_rise_m)) == $past(pin_rise_m))
      else $error("rising edge lost");
   level_all_a: assert property (
      (s.ctl[1].seq == cpi_pkg::CPI_READY && s.ctl[1].ls && !wr_ok && !rd_take) [*2]
      |-> s.ctl[1].pend == s.ctl[1].lvl)
      else $error("level mode not on all inputs");
   // Nothing is pending before the word sequence completes.
   no_early_a: assert property (
      s.ctl[0].seq != cpi_pkg::CPI_READY |-> s.ctl[0].pend == 8'h00 && !o_core_int)
      else $error("request before init");
   slave_idle_a: assert property (
      s.ctl[1].seq != cpi_pkg::CPI_READY |-> s.ctl[1].pend == 8'h00)
      else $error("slave request before init");
   uninit_odd_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ODD && s.ctl[0].seq == cpi_pkg::CPI_UNINIT)
      |=> s.ctl[0].seq == cpi_pkg::CPI_UNINIT && $stable(s.ctl[0].base))
      else $error("word taken before first word");
   // Odd index words are taken strictly in order.
   base_store_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ODD && s.ctl[0].seq == cpi_pkg::CPI_WANT_TWO)
      |=> s.ctl[0].base == $past(i_avs_writedata[7:3])
      && s.ctl[0].seq == cpi_pkg::CPI_WANT_THREE)
      else $error("vector base not stored");
   casc_store_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_M_ODD && s.ctl[0].seq == cpi_pkg::CPI_WANT_THREE)
      |=> s.ctl[0].cascade == {$past(i_avs_writedata[7:1]), 1'b0})
      else $error("cascade map not stored");
   slave_map_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_S_ODD && s.ctl[1].seq == cpi_pkg::CPI_WANT_THREE)
      |=> $stable(s.ctl[0].cascade) && s.ctl[1].seq == cpi_pkg::CPI_WANT_FOUR)
      else $error("slave third word misrouted");
   order_a: assert property (
      (wr_ok && idx == cpi_pkg::IDX_S_ODD && s.ctl[1].seq == cpi_pkg::CPI_WANT_FOUR)
      |=> s.ctl[1].seq == cpi_pkg::CPI_READY)
      else $error("fourth word not taken");
   // Cascade and acknowledge.
   casc_level_a: assert property (
      (s.ctl[0].seq == cpi_pkg::CPI_READY && s.ctl[0].cascade[2] && !wr_ok && !rd_take)
      |=> s.ctl[0].pend[2] == $past(win_s[3]))
      else $error("internal slave not seen on input two");
   ack_vec_a: assert property (
      (rd_take && idx == cpi_pkg::IDX_ACK && win_m[3] && !casc_hit)
      |=> o_avs_readdata[8:0] == {1'b1, $past(s.ctl[0].base), $past(win_m[2:0])}
      && !o_avs_waitrequest)
      else $error("acknowledge vector wrong");
   ack_casc_a: assert property (
      (rd_take && idx == cpi_pkg::IDX_ACK && casc_hit)
      |=> o_avs_readdata[8:0] == {1'b1, $past(s.ctl[1].base), $past(win_s[2:0])})
      else $error("cascaded vector wrong");
   ack_clear_a: assert property (
      (rd_take && idx == cpi_pkg::IDX_ACK && win_m[3] && !casc_hit && !s.ctl[0].ls
      && !rise_m[win_m[2:0]]) |=> !s.ctl[0].pend[$past(win_m[2:0])])
      else $error("serviced edge request not cleared");
endmodule // cpi_top

// ==== test/cpi_core_model.sv ====
// Core software model that writes controller words over the Avalon-MM bus.
`timescale 1ns/1ns
module cpi_core_model (
   // Clock
   input wire logic i_core_clk,
   // Avalon-MM master
   input wire logic [31:0] i_avs_readdata,
   input wire logic i_avs_waitrequest,
   output logic [9:0] o_avs_address,
   output logic o_avs_read,
   output logic o_avs_write,
   output logic [31:0] o_avs_writedata
);
   initial begin
      o_avs_address = 10'h000;
      o_avs_read = 1'b0;
      o_avs_write = 1'b0;
      o_avs_writedata = 32'h0000_0000;
   end
   // Holds the request until waitrequest is seen low at a rising edge.
   task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
      logic ok;
      ok = 1'b0;
      @(posedge i_core_clk);
      o_avs_address <= {idx, 2'b00};
      o_avs_read <= rd;
      o_avs_write <= !rd;
      o_avs_writedata <= {24'h00_0000, d};
      while (!ok) begin
         @(posedge i_core_clk);
         ok = !i_avs_waitrequest;
      end
      q = i_avs_readdata;
      o_avs_read <= 1'b0;
      o_avs_write <= 1'b0;
   endtask
   // Writes the four words in order; no request source is active before this.
   task automatic init(input logic [7:0] one, input logic ls, input logic [4:0] base,
                       input logic [7:0] casc);
      logic [31:0] q;
      xfer(1'b0, one, {3'h0, 1'b1, ls, 3'h1}, q);
      xfer(1'b0, one | 8'h01, {base, 3'h0}, q);
      xfer(1'b0, one | 8'h01, {casc[7:1], 1'b0}, q);
      xfer(1'b0, one | 8'h01, 8'h01, q);
   endtask
endmodule // cpi_core_model

// ==== test/tb.sv ====
// Self-checking testbench for the controller pair initialization path.
`timescale 1ns/1ns
module tb;
   logic i_core_clk;
   logic i_srst;
   logic [9:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [7:0] irq_m;
   logic [7:0] irq_s;
   logic core_int;
   cpi_pkg::cpi_op_t op_word;
   cpi_pkg::cpi_op_t opq[$];
   int bad_count;
   int comparisons;
   int seed;
   int cyc;
   logic [31:0] q;
   logic [4:0] mb;
   logic [4:0] sb;
   logic [7:0] casc;
   logic [7:0] d;
   // ------------------------------------------------------------
   // Clock, instances and monitors.
   // ------------------------------------------------------------
   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = !i_core_clk;
   end
   cpi_top u_cpi_top (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
      .i_irq_master(irq_m), .i_irq_slave(irq_s), .o_core_int(core_int), .o_op_word(op_word));
   cpi_core_model u_cpi_core_model (.i_core_clk(i_core_clk), .i_avs_readdata(avs_readdata),
      .i_avs_waitrequest(avs_waitrequest), .o_avs_address(avs_address),
      .o_avs_read(avs_read), .o_avs_write(avs_write), .o_avs_writedata(avs_writedata));
   always @(negedge i_core_clk) begin
      if (op_word.valid === 1'b1) opq.push_back(op_word);
   end
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end
   // ------------------------------------------------------------
   // Helpers.
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      u_cpi_core_model.xfer(1'b1, idx, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic results();
      $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      seed = 65;
      bad_count = 0;
      comparisons = 0;
      cyc = 0;
      i_srst = 1'b1;
      irq_m = 8'h00;
      irq_s = 8'h00;
      repeat (20) @(posedge i_core_clk);
      i_srst <= 1'b0;
      u_cpi_core_model.xfer(1'b0, cpi_pkg::IDX_M_ODD, 8'hf8, q);
      rdchk(cpi_pkg::IDX_VECTOR, 32'h0000_0000);
      rdchk(8'h3f, 32'h0000_0000);
      mb = 5'($random(seed));
      sb = 5'($random(seed));
      casc = 8'($random(seed)) | 8'h04;
      u_cpi_core_model.init(cpi_pkg::IDX_M_ONE, 1'b0, mb, casc);
      u_cpi_core_model.init(cpi_pkg::IDX_S_ONE, 1'b1, sb, 8'h02);
      rdchk(cpi_pkg::IDX_STATUS, {16'h0000, casc & 8'hfe, 8'h0d});
      chk({24'h00_0000, q[15:8]}, {24'h00_0000, casc & 8'hfe});
      rdchk(cpi_pkg::IDX_VECTOR, {19'h0, sb, 3'h0, mb});
      chk(32'(opq.size()), 32'h0000_0000);
      for (int k = 0; k < 2; k++) begin
         d = 8'($random(seed)) & 8'hef;
         u_cpi_core_model.xfer(1'b0, k[0] ? cpi_pkg::IDX_S_ONE : cpi_pkg::IDX_M_ONE, d, q);
         repeat (2) @(negedge i_core_clk);
         chk({21'h0, opq.pop_front()}, {21'h0, 1'b1, k[0], d[3], d});
      end
      @(posedge i_core_clk);
      irq_m[5] <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      rdchk(cpi_pkg::IDX_PEND, 32'h0000_0020);
      chk({31'h0, core_int}, 32'h0000_0001);
      u_cpi_core_model.xfer(1'b0, cpi_pkg::IDX_M_ODD, 8'h20, q);
      @(posedge i_core_clk);
      chk({31'h0, core_int}, 32'h0000_0000);
      u_cpi_core_model.xfer(1'b0, cpi_pkg::IDX_M_ODD, 8'h00, q);
      irq_s[3] <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      rdchk(cpi_pkg::IDX_ACK, {23'h0, 1'b1, sb, 3'h3});
      irq_s[3] <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      rdchk(cpi_pkg::IDX_ACK, {23'h0, 1'b1, mb, 3'h5});
      rdchk(cpi_pkg::IDX_PEND, 32'h0000_0000);
      chk({31'h0, core_int}, 32'h0000_0000);
      results();
   end
endmodule // tb
